// ### design/adcc_eng_if.sv
// Link between the register side and the conversion sequencer.
`timescale 1ns/10ps
interface adcc_eng_if;
    logic       start;
    logic       abort;
    logic [1:0] clk_sel;
    logic       busy;
    logic       done;
    logic       hold_connect;

    modport ctrl
    (
        output start,
        output abort,
        output clk_sel,
        input  busy,
        input  done,
        input  hold_connect
    );

    modport eng
    (
        input  start,
        input  abort,
        input  clk_sel,
        output busy,
        output done,
        output hold_connect
    );
endinterface

// ### design/adcc_pkg.sv
// Shared constants and types of the converter control block.
package adcc_pkg;

    // Register byte addresses.
    localparam logic [7:0] ADDR_PORT_DATA      = 8'h05;
    localparam logic [7:0] ADDR_DONE_FLAG      = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ENABLE     = 8'h8C;
    localparam logic [7:0] ADDR_RESULT_HIGH    = 8'h1E;
    localparam logic [7:0] ADDR_RESULT_LOW     = 8'h9E;
    localparam logic [7:0] ADDR_CONV_CONTROL   = 8'h1F;
    localparam logic [7:0] ADDR_PORT_ANALOG    = 8'h9F;

    // Field positions.
    localparam int CTL_CLK_SEL_LSB   = 6;
    localparam int CTL_CHAN_LSB      = 3;
    localparam int CTL_GO_BIT        = 2;
    localparam int CTL_ON_BIT        = 0;
    localparam int CFG_JUSTIFY_BIT   = 7;
    localparam int CFG_PIN_LSB       = 0;
    localparam int FLAG_DONE_BIT     = 6;
    localparam int FLAG_IRQ_EN_BIT   = 6;

    // Values after reset.
    localparam logic [7:0] RESET_CONV_CONTROL = 8'h00;
    localparam logic [3:0] RESET_PIN_ASSIGN   = 4'h0;
    localparam logic       RESET_JUSTIFY      = 1'b0;
    localparam logic [7:0] RESET_RESULT       = 8'h00;

    // Conversion clock and sequencing.
    localparam int CLK_PERIOD_NS   = 20;
    localparam int RC_TAD_NS       = 4000;
    localparam int TAD_CYCLES_2    = 2;
    localparam int TAD_CYCLES_8    = 8;
    localparam int TAD_CYCLES_32   = 32;
    localparam int TAD_CYCLES_RC   = (RC_TAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_TAD_COUNT  = 12;
    localparam int RECOV_TAD_COUNT = 2;

    localparam logic [1:0] CLK_SEL_2TOSC  = 2'h0;
    localparam logic [1:0] CLK_SEL_8TOSC  = 2'h1;
    localparam logic [1:0] CLK_SEL_32TOSC = 2'h2;
    localparam logic [1:0] CLK_SEL_RC     = 2'h3;

    // Pin assignment table: analog input mask, upper reference pin, lower reference pin.
    typedef struct packed
    {
        logic [7:0] analog_mask;
        logic       vref_hi_pin;
        logic       vref_lo_pin;
    } adcc_pin_map_s;

    localparam adcc_pin_map_s PIN_MAP [16] = '{
        '{8'hFF, 1'b0, 1'b0},
        '{8'hF7, 1'b1, 1'b0},
        '{8'h1F, 1'b0, 1'b0},
        '{8'h17, 1'b1, 1'b0},
        '{8'h0B, 1'b0, 1'b0},
        '{8'h03, 1'b1, 1'b0},
        '{8'h00, 1'b0, 1'b0},
        '{8'h00, 1'b0, 1'b0},
        '{8'hF3, 1'b1, 1'b1},
        '{8'h3F, 1'b0, 1'b0},
        '{8'h37, 1'b1, 1'b0},
        '{8'h33, 1'b1, 1'b1},
        '{8'h13, 1'b1, 1'b1},
        '{8'h03, 1'b1, 1'b1},
        '{8'h01, 1'b0, 1'b0},
        '{8'h01, 1'b1, 1'b1}
    };

    // Pins that exist on the small package.
    localparam logic [7:0] SMALL_PKG_MASK = 8'h1F;

    typedef enum logic [1:0] { ENG_IDLE, ENG_CONVERT, ENG_RECOVER } adcc_eng_e;

endpackage

// ### design/adcc_sequencer.sv
// Conversion sequencer: bit period divider, conversion count and recovery gap.
`timescale 1ns/10ps
module adcc_sequencer
(
    // Clock and reset.
    input  wire logic  sys_clk,
    input  wire logic  reset,
    // Control link.
    adcc_eng_if.eng    link
);

    typedef struct packed
    {
        adcc_pkg::adcc_eng_e st;
        logic [7:0]          tcnt;
        logic [3:0]          bits;
        logic                done;
    } adcc_seq_s;

    adcc_seq_s  seq_q;
    adcc_seq_s  seq_d;
    logic [7:0] tad_len;
    logic       tad_tick;

    always_comb
    begin
        case (link.clk_sel)
            adcc_pkg::CLK_SEL_2TOSC:  tad_len = 8'(adcc_pkg::TAD_CYCLES_2);
            adcc_pkg::CLK_SEL_8TOSC:  tad_len = 8'(adcc_pkg::TAD_CYCLES_8);
            adcc_pkg::CLK_SEL_32TOSC: tad_len = 8'(adcc_pkg::TAD_CYCLES_32);
            default:                  tad_len = 8'(adcc_pkg::TAD_CYCLES_RC);
        endcase
    end

    assign tad_tick = (seq_q.tcnt == tad_len - 8'h01);

    always_comb
    begin
        seq_d      = seq_q;
        seq_d.done = 1'b0;
        seq_d.tcnt = tad_tick ? 8'h00 : seq_q.tcnt + 8'h01;
        case (seq_q.st)
            adcc_pkg::ENG_IDLE:
            begin
                seq_d.tcnt = 8'h00;
                if (link.start)
                begin
                    seq_d.st   = adcc_pkg::ENG_CONVERT;
                    seq_d.bits = 4'h0;
                end
            end
            adcc_pkg::ENG_CONVERT:
            begin
                if (link.abort)
                begin
                    seq_d.st   = adcc_pkg::ENG_RECOVER;
                    seq_d.bits = 4'h0;
                    seq_d.tcnt = 8'h00;
                end
                else if (tad_tick)
                begin
                    seq_d.bits = seq_q.bits + 4'h1;
                    if (seq_q.bits == 4'(adcc_pkg::CONV_TAD_COUNT - 1))
                    begin
                        seq_d.st   = adcc_pkg::ENG_RECOVER;
                        seq_d.bits = 4'h0;
                        seq_d.done = 1'b1;
                    end
                end
            end
            adcc_pkg::ENG_RECOVER:
            begin
                if (tad_tick)
                begin
                    seq_d.bits = seq_q.bits + 4'h1;
                    if (seq_q.bits == 4'(adcc_pkg::RECOV_TAD_COUNT - 1))
                    begin
                        seq_d.st   = adcc_pkg::ENG_IDLE;
                        seq_d.bits = 4'h0;
                    end
                end
            end
            default:
            begin
                seq_d.st = adcc_pkg::ENG_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            seq_q.st   <= adcc_pkg::ENG_IDLE;
            seq_q.tcnt <= 8'h00;
            seq_q.bits <= 4'h0;
            seq_q.done <= 1'b0;
        end
        else
        begin
            seq_q <= seq_d;
        end
    end

    assign link.busy         = (seq_q.st != adcc_pkg::ENG_IDLE);
    assign link.done         = seq_q.done;
    // The hold capacitor tracks the channel only while idle.
    assign link.hold_connect = (seq_q.st == adcc_pkg::ENG_IDLE);

endmodule

// ### design/adcc_top.sv
// Converter control: pin assignment, result registers and conversion sequencing.
//
// Function
// - Ten-bit result in high/low byte pair.
// - Right justify clears upper six high bits.
// - Left justify clears lower six low bits.
// - Config bits six to four read zero.
// - Four-bit code decodes per-pin analog assignment.
// - Code selects reference sources and counts.
// - Small package lacks channels five to seven.
// - Completion loads result, clears go, flags.
// - Writing go with converter already on and not busy starts converting selected channel.
// - Two bit periods pass before reacquisition.
// - Clock select picks bit period length.
// - Clearing go aborts, result stays unchanged.
// - Port reads zero on analog pins.
`timescale 1ns/10ps
module adcc_top
#(
    parameter bit SMALL_PACKAGE = 1'b0
)
(
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // Register port.
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Converter data and pin levels.
    input  wire logic [9:0] conv_sample,
    input  wire logic [7:0] port_pin_level,
    // Pin and reference assignment.
    output logic      [7:0] pin_analog_mask,
    output logic            vref_hi_from_pin,
    output logic            vref_lo_from_pin,
    output logic      [3:0] analog_chan_count,
    output logic      [1:0] ref_pin_count,
    // Converter control.
    output logic      [2:0] channel_select,
    output logic            converter_on,
    output logic            hold_connect,
    output logic            conv_done_flag,
    output logic            conv_done_irq_enable
);

    typedef struct packed
    {
        logic [1:0] clk_sel;
        logic [2:0] chan;
        logic       go;
        logic       on;
        logic       justify;
        logic [3:0] pin_assign;
        logic [7:0] res_hi;
        logic [7:0] res_lo;
        logic       flag;
        logic       irq_en;
        logic [7:0] rdata;
        logic [7:0] mask;
        logic       vhi;
        logic       vlo;
        logic [3:0] ccount;
        logic [1:0] rcount;
        logic       start;
        logic       abort;
        logic       hold;
    } adcc_top_s;

    adcc_top_s   st_q;
    adcc_top_s   st_d;
    adcc_eng_if  eng_link ();

    assign eng_link.start   = st_q.start;
    assign eng_link.abort   = st_q.abort;
    assign eng_link.clk_sel = st_q.clk_sel;

    adcc_sequencer u_seq
    (
        .sys_clk (sys_clk),
        .reset   (reset),
        .link    (eng_link)
    );

    always_comb
    begin
        logic                    wr_ctl;
        logic                    wr_cfg;
        logic [3:0]              cfg_next;
        logic [7:0]              m;
        logic [3:0]              n;
        adcc_pkg::adcc_pin_map_s map;
        wr_ctl   = reg_wr && (reg_addr == adcc_pkg::ADDR_CONV_CONTROL);
        wr_cfg   = reg_wr && (reg_addr == adcc_pkg::ADDR_PORT_ANALOG);
        cfg_next = st_q.pin_assign;
        m        = 8'h00;
        n        = 4'h0;
        map      = adcc_pkg::PIN_MAP[0];
        st_d       = st_q;
        st_d.start = 1'b0;
        st_d.abort = 1'b0;
        st_d.hold  = eng_link.hold_connect;

        // Conversion control writes.
        if (wr_ctl)
        begin
            st_d.clk_sel = reg_wdata[adcc_pkg::CTL_CLK_SEL_LSB +: 2];
            st_d.chan    = reg_wdata[adcc_pkg::CTL_CHAN_LSB +: 3];
            st_d.on      = reg_wdata[adcc_pkg::CTL_ON_BIT];
            if (st_q.go && (!reg_wdata[adcc_pkg::CTL_GO_BIT] || !reg_wdata[adcc_pkg::CTL_ON_BIT]))
            begin
                st_d.go    = 1'b0;
                st_d.abort = eng_link.busy;
            end
            else if (!st_q.go && reg_wdata[adcc_pkg::CTL_GO_BIT] && st_q.on && !eng_link.busy)
            begin
                st_d.go    = 1'b1;
                st_d.start = 1'b1;
            end
        end

        if (wr_cfg)
        begin
            st_d.justify    = reg_wdata[adcc_pkg::CFG_JUSTIFY_BIT];
            st_d.pin_assign = reg_wdata[adcc_pkg::CFG_PIN_LSB +: 4];
            cfg_next        = reg_wdata[adcc_pkg::CFG_PIN_LSB +: 4];
        end

        // Result bytes are plain storage between conversions.
        if (reg_wr && (reg_addr == adcc_pkg::ADDR_RESULT_HIGH))
        begin
            st_d.res_hi = reg_wdata;
        end
        if (reg_wr && (reg_addr == adcc_pkg::ADDR_RESULT_LOW))
        begin
            st_d.res_lo = reg_wdata;
        end
        if (reg_wr && (reg_addr == adcc_pkg::ADDR_IRQ_ENABLE))
        begin
            st_d.irq_en = reg_wdata[adcc_pkg::FLAG_IRQ_EN_BIT];
        end
        if (reg_wr && (reg_addr == adcc_pkg::ADDR_DONE_FLAG))
        begin
            st_d.flag = reg_wdata[adcc_pkg::FLAG_DONE_BIT];
        end

        if (eng_link.done && st_q.go)
        begin
            st_d.go   = 1'b0;
            st_d.flag = 1'b1;
            if (st_q.justify)
            begin
                st_d.res_hi = {6'h00, conv_sample[9:8]};
                st_d.res_lo = conv_sample[7:0];
            end
            else
            begin
                st_d.res_hi = conv_sample[9:2];
                st_d.res_lo = {conv_sample[1:0], 6'h00};
            end
        end

        map = adcc_pkg::PIN_MAP[cfg_next];
        m   = map.analog_mask;
        if (SMALL_PACKAGE)
        begin
            m = m & adcc_pkg::SMALL_PKG_MASK;
        end
        for (int i = 0; i < 8; i++)
        begin
            n = n + 4'(m[i]);
        end
        st_d.mask   = m;
        st_d.vhi    = map.vref_hi_pin;
        st_d.vlo    = map.vref_lo_pin;
        st_d.ccount = n;
        st_d.rcount = 2'(map.vref_hi_pin) + 2'(map.vref_lo_pin);

        // Read data stand in the cycle after the strobe only.
        st_d.rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                adcc_pkg::ADDR_CONV_CONTROL:
                    st_d.rdata = {st_q.clk_sel, st_q.chan, st_q.go, 1'b0, st_q.on};
                adcc_pkg::ADDR_PORT_ANALOG:
                    st_d.rdata = {st_q.justify, 3'h0, st_q.pin_assign};
                adcc_pkg::ADDR_RESULT_HIGH:
                    st_d.rdata = st_q.res_hi;
                adcc_pkg::ADDR_RESULT_LOW:
                    st_d.rdata = st_q.res_lo;
                adcc_pkg::ADDR_DONE_FLAG:
                    st_d.rdata = 8'(st_q.flag) << adcc_pkg::FLAG_DONE_BIT;
                adcc_pkg::ADDR_IRQ_ENABLE:
                    st_d.rdata = 8'(st_q.irq_en) << adcc_pkg::FLAG_IRQ_EN_BIT;
                adcc_pkg::ADDR_PORT_DATA:
                    st_d.rdata = port_pin_level & ~st_q.mask;
                default:
                    st_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            st_q.clk_sel    <= adcc_pkg::RESET_CONV_CONTROL[adcc_pkg::CTL_CLK_SEL_LSB +: 2];
            st_q.chan       <= adcc_pkg::RESET_CONV_CONTROL[adcc_pkg::CTL_CHAN_LSB +: 3];
            st_q.go         <= adcc_pkg::RESET_CONV_CONTROL[adcc_pkg::CTL_GO_BIT];
            st_q.on         <= adcc_pkg::RESET_CONV_CONTROL[adcc_pkg::CTL_ON_BIT];
            st_q.justify    <= adcc_pkg::RESET_JUSTIFY;
            st_q.pin_assign <= adcc_pkg::RESET_PIN_ASSIGN;
            st_q.res_hi     <= adcc_pkg::RESET_RESULT;
            st_q.res_lo     <= adcc_pkg::RESET_RESULT;
            st_q.flag       <= 1'b0;
            st_q.irq_en     <= 1'b0;
            st_q.rdata      <= 8'h00;
            st_q.mask       <= adcc_pkg::PIN_MAP[0].analog_mask & (SMALL_PACKAGE ? adcc_pkg::SMALL_PKG_MASK : 8'hFF);
            st_q.vhi        <= 1'b0;
            st_q.vlo        <= 1'b0;
            st_q.ccount     <= SMALL_PACKAGE ? 4'h5 : 4'h8;
            st_q.rcount     <= 2'h0;
            st_q.start      <= 1'b0;
            st_q.abort      <= 1'b0;
            st_q.hold       <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign reg_rdata            = st_q.rdata;
    assign pin_analog_mask      = st_q.mask;
    assign vref_hi_from_pin     = st_q.vhi;
    assign vref_lo_from_pin     = st_q.vlo;
    assign analog_chan_count    = st_q.ccount;
    assign ref_pin_count        = st_q.rcount;
    assign channel_select       = st_q.chan;
    assign converter_on         = st_q.on;
    assign hold_connect         = st_q.hold;
    assign conv_done_flag       = st_q.flag;
    assign conv_done_irq_enable = st_q.irq_en;

endmodule

// ### verif/adcc_analog_model.sv
// Analog pin and hold capacitor model at the far side of the converter control.
`timescale 1ns/10ps
module adcc_analog_model
(
    // Clock.
    input  wire logic       sys_clk,
    // Switch and channel from the block.
    input  wire logic       hold_connect,
    input  wire logic [2:0] channel_select,
    // Pin level in and held sample out.
    input  wire logic [9:0] ain,
    output logic      [9:0] conv_sample
);
    // The capacitor keeps its charge while the switch is open.
    // pins only sensed, never driven
    always_ff @(posedge sys_clk)
        if (hold_connect)
            conv_sample <= ain ^ {7'h00, channel_select};
endmodule

// ### verif/adcc_props.sv
// Concurrent checks on the ports of the converter control top.
`timescale 1ns/10ps
module adcc_props
#(
    parameter bit SMALL_PACKAGE = 1'b0
)
(
    input wire logic       sys_clk,
    input wire logic       reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [9:0] conv_sample,
    input wire logic [7:0] port_pin_level,
    input wire logic [7:0] pin_analog_mask,
    input wire logic       vref_hi_from_pin,
    input wire logic       vref_lo_from_pin,
    input wire logic [3:0] analog_chan_count,
    input wire logic [1:0] ref_pin_count,
    input wire logic [2:0] channel_select,
    input wire logic       converter_on,
    input wire logic       hold_connect,
    input wire logic       conv_done_flag,
    input wire logic       conv_done_irq_enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_cfg_wr;
        reg_wr && reg_addr == adcc_pkg::ADDR_PORT_ANALOG;
    endsequence
    sequence s_recover;
        !hold_connect [*4];
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read");
    a_cfg_unused: assert property (reg_rd && reg_addr == adcc_pkg::ADDR_PORT_ANALOG |=> reg_rdata[6:4] == 3'h0)
        else $error("unused config bits not zero");
    a_port_read: assert property (reg_rd && reg_addr == adcc_pkg::ADDR_PORT_DATA
        |=> reg_rdata == ($past(port_pin_level) & ~$past(pin_analog_mask))) else $error("analog pin not read as zero");
    a_cfg_digital: assert property (s_cfg_wr and reg_wdata[3:1] == 3'h3
        |=> pin_analog_mask == 8'h00 && ref_pin_count == 2'h0) else $error("all digital code not applied");
    a_chan_count: assert property (analog_chan_count == 4'($countones(pin_analog_mask)))
        else $error("channel count wrong");
    a_small_pkg: assert property (SMALL_PACKAGE |-> pin_analog_mask[7:5] == 3'h0)
        else $error("missing channel shown analog");
    a_hold_gap: assert property ($fell(hold_connect) |-> s_recover)
        else $error("hold switch closed too soon");
    a_done_flag: assert property ($rose(conv_done_flag) && !$past(reg_wr) |-> !hold_connect)
        else $error("done flag set outside completion");
endmodule
bind adcc_top adcc_props #(.SMALL_PACKAGE(SMALL_PACKAGE)) u_adcc_props (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_sample(conv_sample), .port_pin_level(port_pin_level), .pin_analog_mask(pin_analog_mask),
    .vref_hi_from_pin(vref_hi_from_pin), .vref_lo_from_pin(vref_lo_from_pin),
    .analog_chan_count(analog_chan_count), .ref_pin_count(ref_pin_count), .channel_select(channel_select),
    .converter_on(converter_on), .hold_connect(hold_connect), .conv_done_flag(conv_done_flag),
    .conv_done_irq_enable(conv_done_irq_enable));

// ### verif/adcc_top_tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
module adcc_top_tb;
    localparam logic [7:0] MAP [16] = '{8'hFF, 8'hF7, 8'h1F, 8'h17, 8'h0B, 8'h03, 8'h00, 8'h00,
                                        8'hF3, 8'h3F, 8'h37, 8'h33, 8'h13, 8'h03, 8'h01, 8'h01};
    localparam logic [15:0] HI = 16'hBD2A;
    localparam logic [15:0] LO = 16'hB900;
    localparam int          ACQ = 1000;
    logic       sys_clk = 1'b0;
    logic       reset = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, lvl = 8'h00, reg_rdata, mask, mask_s, d, v;
    logic       reg_wr = 1'b0, reg_rd = 1'b0, vhi, vlo, hold, flag, ien, on;
    logic [9:0] ain = 10'h000, smp;
    logic [2:0] chan;
    logic [15:0] last = 16'h0000;
    integer     seed = 32'h82ED5191;
    int         error_cnt = 0, n_tests = 0;
    time        t0;

    adcc_top u_adcc_top (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_sample(smp), .port_pin_level(lvl),
        .pin_analog_mask(mask), .vref_hi_from_pin(vhi), .vref_lo_from_pin(vlo), .analog_chan_count(),
        .ref_pin_count(), .channel_select(chan), .converter_on(on), .hold_connect(hold), .conv_done_flag(flag),
        .conv_done_irq_enable(ien));
    adcc_top #(.SMALL_PACKAGE(1'b1)) u_adcc_top_s (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .conv_sample(smp),
        .port_pin_level(lvl), .pin_analog_mask(mask_s), .vref_hi_from_pin(), .vref_lo_from_pin(),
        .analog_chan_count(), .ref_pin_count(), .channel_select(), .converter_on(), .hold_connect(),
        .conv_done_flag(), .conv_done_irq_enable());
    adcc_analog_model u_adcc_analog_model (.sys_clk(sys_clk), .hold_connect(hold), .channel_select(chan),
        .ain(ain), .conv_sample(smp));

    always #10 sys_clk = ~sys_clk;

    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= w;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 r = reg_rdata;
    endtask

    // One conversion, optionally cut short by clearing go.
    task automatic conv(input logic [1:0] sel, input logic j, input logic abort);
        int         bit_conversion_period;
        logic [2:0] c;
        logic [7:0] h;
        logic [15:0] e;
        logic [9:0]  a;
        bit_conversion_period = (sel == 2'h3) ? adcc_pkg::TAD_CYCLES_RC : 2 << (2 * sel);
        c = 3'($random(seed));
        a = 10'($random(seed));
        ain <= a;
        e = j ? {6'h00, a ^ {7'h00, c}} : {a ^ {7'h00, c}, 6'h00};
        wr(adcc_pkg::ADDR_PORT_ANALOG, {j, 7'h00});
        wr(adcc_pkg::ADDR_CONV_CONTROL, {sel, c, 3'h1});
        wr(adcc_pkg::ADDR_DONE_FLAG, 8'h00);
        wr(adcc_pkg::ADDR_IRQ_ENABLE, 8'h40);
        repeat (ACQ) @(posedge sys_clk);
        t0 = $time;
        wr(adcc_pkg::ADDR_CONV_CONTROL, {sel, c, 3'h5});
        if (abort)
        begin
            repeat (10) @(posedge sys_clk);
            wr(adcc_pkg::ADDR_CONV_CONTROL, {sel, c, 3'h1});
            repeat (16 * bit_conversion_period) @(posedge sys_clk);
            e = last;
        end
        d = 8'h04;
        for (int i = 0; i < 13 * bit_conversion_period && d[2]; i++)
            rd(adcc_pkg::ADDR_CONV_CONTROL, d);
        if (!abort)
            chk(16'(($time - t0) / 20 - 12 * bit_conversion_period) < 16'd13, 16'h0001);
        chk({d, 5'h00, on, flag, ien}, {sel, c, 3'h1, 5'h00, 1'b1, !abort, 1'b1});
        rd(adcc_pkg::ADDR_RESULT_HIGH, h);
        rd(adcc_pkg::ADDR_RESULT_LOW, d);
        chk({h, d}, e);
        last = e;
        $display("conversion sel=%0d abort=%0d done", sel, abort);
    endtask

    initial
    begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        rd(adcc_pkg::ADDR_PORT_ANALOG, d);
        chk({d, mask}, 16'h00FF);
        wr(adcc_pkg::ADDR_CONV_CONTROL, 8'h04);
        rd(adcc_pkg::ADDR_CONV_CONTROL, d);
        chk(d, 8'h00);
        for (int k = 0; k < 16; k++)
        begin
            v = 8'($random(seed));
            wr(adcc_pkg::ADDR_PORT_ANALOG, {v[7:4], 4'(k)});
            #1 chk({mask, vhi, vlo, 6'h00}, {MAP[k], HI[k], LO[k], 6'h00});
            chk(mask_s, MAP[k] & 8'h1F);
            rd(adcc_pkg::ADDR_PORT_ANALOG, d);
            chk(d, {v[7], 3'h0, 4'(k)});
            lvl <= 8'($random(seed));
            rd(adcc_pkg::ADDR_PORT_DATA, d);
            chk(d, lvl & ~mask);
        end
        $display("pin assignment sweep done");
        for (int s = 0; s < 4; s++)
            conv(2'(s), s[0], 1'b0);
        conv(2'h2, 1'b1, 1'b1);
        conclude();
    end

    initial
    begin
        #1_000_000;
        error_cnt++;
        conclude();
    end
endmodule
